// ==== src/eeprom_prog_pkg.sv ====
// Package of constants and types for the serial EEPROM program control block.
package eeprom_prog_pkg;
  localparam int ADDR_W      = 6;
  localparam int DATA_W      = 16;
  localparam int OPC_W       = 2;
  localparam logic [1:0] OPC_SPECIAL = 2'h0;
  localparam logic [1:0] OPC_WRITE   = 2'h1;
  localparam logic [1:0] OPC_READ    = 2'h2;
  localparam logic [1:0] OPC_ERASE   = 2'h3;
  localparam logic [1:0] SUB_DISABLE = 2'h0;
  localparam logic [1:0] SUB_FILL    = 2'h1;
  localparam logic [1:0] SUB_CLEAR   = 2'h2;
  localparam logic [1:0] SUB_ENABLE  = 2'h3;
  localparam int CLK_MHZ        = 25;
  localparam int PROG_TIME_US   = 5;
  localparam int PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
  localparam int CNT_W          = 16;
  typedef enum logic [2:0] {
    OP_NONE, OP_WRITE, OP_ERASE, OP_CLEAR_ALL, OP_FILL_ALL
  } prog_op_t;
endpackage : eeprom_prog_pkg

// ==== src/link_cmd_if.sv ====
// Interface carrying decoded commands from the link domain to the core domain.
interface link_cmd_if;
  import eeprom_prog_pkg::*;
  logic                     cmd_toggle;
  eeprom_prog_pkg::prog_op_t cmd_op;
  logic [ADDR_W-1:0]        cmd_addr;
  logic [DATA_W-1:0]        cmd_data;
  logic                     wen_toggle;
  logic                     wen_value;
  logic                     dummy_one;
  modport link (output cmd_toggle, cmd_op, cmd_addr, cmd_data, wen_toggle, wen_value, dummy_one);
  modport core (input  cmd_toggle, cmd_op, cmd_addr, cmd_data, wen_toggle, wen_value, dummy_one);
endinterface : link_cmd_if

// ==== src/link_shifter.sv ====
// Link-clock instruction shifter: collects start bit, opcode, address and data.
module link_shifter
  import eeprom_prog_pkg::*;
(
  // Link side.
  input  wire logic serial_clock_in,
  input  wire logic chip_select,
  input  wire logic serial_in,
  // Toward the core domain.
  link_cmd_if.link  cmd
);
  import eeprom_prog_pkg::*;

  localparam int TOT_W = 1 + OPC_W + ADDR_W + DATA_W;
  localparam int CNT_BITS = $clog2(TOT_W + 2);

  logic [TOT_W-1:0]    shift_r;
  logic [CNT_BITS-1:0] count_r;
  logic                done_r;
  logic                cmd_toggle_r;
  logic                wen_toggle_r;
  logic                wen_value_r;
  prog_op_t            op_r;
  logic                dummy_r;
  logic [ADDR_W-1:0]   addr_r;
  logic [DATA_W-1:0]   data_r;

  // Fields of the word shifted so far, start bit leading.
  wire logic [CNT_BITS-1:0] hdr_len = CNT_BITS'(1 + OPC_W + ADDR_W);
  wire logic [CNT_BITS-1:0] full_len = CNT_BITS'(TOT_W);
  wire logic                started = shift_r[0] | (count_r != '0);
  wire logic [OPC_W-1:0]    opc = shift_r[ADDR_W +: OPC_W];
  wire logic [1:0]          sub = shift_r[ADDR_W-1 -: 2];
  wire logic [OPC_W-1:0]    opc_d = shift_r[ADDR_W+DATA_W +: OPC_W];
  wire logic [1:0]          sub_d = shift_r[ADDR_W+DATA_W-1 -: 2];

  // Bits are taken on the rising serial clock while selected; the frame ends with select.
  // The opcode decides whether data follows, so the frame completes at header or full length.
  always_ff @(posedge serial_clock_in or negedge chip_select) begin
    if (!chip_select) begin
      shift_r <= '0;
      count_r <= '0;
      done_r  <= 1'b0;
      dummy_r <= 1'b0;
    end else begin
      dummy_r <= serial_in; // Any one bit after a frame releases the status output.
      if (!done_r && (started || serial_in)) begin
        shift_r <= {shift_r[TOT_W-2:0], serial_in};
        count_r <= count_r + 1'b1;
      end
      if (count_r + 1'b1 == hdr_len && !done_r) begin
        done_r <= !(shift_r[ADDR_W -: OPC_W] == OPC_WRITE) &&
                  !({shift_r[OPC_W+ADDR_W-2:ADDR_W-1]} == OPC_SPECIAL && shift_r[ADDR_W-2:ADDR_W-3] == SUB_FILL);
      end else if (count_r + 1'b1 == full_len) begin
        done_r <= 1'b1;
      end
    end
  end

  // Decode a finished frame into the operation latched at the select edge.
  prog_op_t op_sel;
  always_comb begin
    op_sel = OP_NONE;
    if (count_r == hdr_len) begin
      if (opc == OPC_ERASE) op_sel = OP_ERASE;
      else if (opc == OPC_SPECIAL && sub == SUB_CLEAR) op_sel = OP_CLEAR_ALL;
    end else if (count_r == full_len) begin
      if (opc_d == OPC_WRITE) op_sel = OP_WRITE;
      else if (opc_d == OPC_SPECIAL && sub_d == SUB_FILL) op_sel = OP_FILL_ALL;
    end
  end
  wire logic is_en  = count_r == hdr_len && opc == OPC_SPECIAL && sub == SUB_ENABLE;
  wire logic is_dis = count_r == hdr_len && opc == OPC_SPECIAL && sub == SUB_DISABLE;

  // Commands and their fields are held from one select fall to the next, because the
  // shift register clears as soon as select drops. The core sees the fall through its own
  // synchroniser, so these levels have long settled when it reads them.
  always_ff @(negedge chip_select) begin
    op_r         <= op_sel;
    cmd_toggle_r <= op_sel != OP_NONE;
    wen_toggle_r <= is_en || is_dis;
    wen_value_r  <= is_en;
    addr_r       <= (op_sel == OP_WRITE || op_sel == OP_FILL_ALL) ? shift_r[DATA_W +: ADDR_W] : shift_r[ADDR_W-1:0];
    data_r       <= shift_r[DATA_W-1:0];
  end

  assign cmd.cmd_toggle = cmd_toggle_r;
  assign cmd.cmd_op     = op_r;
  assign cmd.cmd_addr   = addr_r;
  assign cmd.cmd_data   = data_r;
  assign cmd.wen_toggle = wen_toggle_r;
  assign cmd.wen_value  = wen_value_r;
  assign cmd.dummy_one  = dummy_r;
endmodule : link_shifter

// ==== src/eeprom_prog_ctrl.sv ====
// Program and erase control of a serial EEPROM behind a three-wire link.
// Summary of operation
// - After reset writes are disabled; program and clear instructions are refused.
// - Write enable persists until reset or a disable-writes instruction.
// - While disabled, write, erase, clear-all and fill-all are all blocked.
// - The word view returns array data whatever the write-enable state; read instructions are not decoded.
// - Select falling edge launches a self-timed clear then store for writes.
// - Internal cycles finish on the core clock with no serial clock.
// - Host may select during a cycle and read ready/busy on serial out.
// - Writes pre-clear automatically so no prior erase is needed.
// - Single erase sets every bit of the addressed word to one.
// - Clear-all sets every bit of the whole array to one.
// - Fill-all stores the data word into every location.
// - Instructions are start bit, opcode, address, and data for writes.
// - Instruction bits are sampled on rising serial clock edges.
// - Busy polls show serial out low, ready shows high.
module eeprom_prog_ctrl
  import eeprom_prog_pkg::*;
#(
  parameter int PROG_COUNT = PROG_CYCLES
)(
  // Core clock and reset.
  input  wire logic                        clock,
  input  wire logic                        rst_b,
  // Serial link.
  input  wire logic                        serial_clock_in,
  input  wire logic                        chip_select,
  input  wire logic                        serial_in,
  output logic                             serial_out,
  output logic                             serial_out_en,
  // Status and array word view.
  output logic                             busy,
  output logic                             write_enabled,
  input  wire logic [eeprom_prog_pkg::ADDR_W-1:0] peek_addr,
  output logic [eeprom_prog_pkg::DATA_W-1:0]      peek_data
);
  import eeprom_prog_pkg::*;

  localparam int WORDS = 1 << ADDR_W;
  localparam logic [CNT_W-1:0] PHASE_CNT = CNT_W'(PROG_COUNT);

  typedef enum {S_IDLE, S_CLEAR, S_STORE} prog_state_t;

  link_cmd_if cmd_bus ();

  link_shifter u_shift (
    .serial_clock_in (serial_clock_in),
    .chip_select     (chip_select),
    .serial_in       (serial_in),
    .cmd             (cmd_bus.link)
  );

  logic [DATA_W-1:0] mem_r [WORDS];
  logic [2:0] cs_sync_r;
  logic [1:0] dum_sync_r;
  logic       wen_r;
  logic       poll_r;
  prog_state_t state_r;
  prog_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  prog_op_t   op_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] data_r;

  // Command fields are stable long before the toggle is seen, since select must stay low.
  wire logic cs_now  = cs_sync_r[1];
  wire logic cs_fall = cs_sync_r[2] & ~cs_sync_r[1];
  wire logic cmd_evt = cs_fall && cmd_bus.cmd_toggle;
  wire logic wen_evt = cs_fall && cmd_bus.wen_toggle;
  wire logic start   = cmd_evt && wen_r && state_r == S_IDLE;
  wire logic phase_done = cnt_r == PHASE_CNT - 1'b1;
  wire logic whole   = op_r == OP_CLEAR_ALL || op_r == OP_FILL_ALL;

  // Two-flop crossings for the dummy-one bit and the select level.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cs_sync_r  <= '0;
      dum_sync_r <= '0;
    end else begin
      cs_sync_r  <= {cs_sync_r[1:0], chip_select};
      dum_sync_r <= {dum_sync_r[0], cmd_bus.dummy_one};
    end
  end

  // Write-enable latch: cleared by reset, changed only by enable or disable instructions.
  always_ff @(posedge clock) begin
    if (!rst_b) wen_r <= 1'b0;
    else if (wen_evt) wen_r <= cmd_bus.wen_value;
  end

  // Next state of the self-timed cycle.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE:  if (start) state_nxt = (cmd_bus.cmd_op == OP_ERASE || cmd_bus.cmd_op == OP_CLEAR_ALL) ? S_CLEAR : S_CLEAR;
      S_CLEAR: if (phase_done) state_nxt = (op_r == OP_WRITE || op_r == OP_FILL_ALL) ? S_STORE : S_IDLE;
      S_STORE: if (phase_done) state_nxt = S_IDLE;
    endcase
  end

  // Cycle timing runs on the core clock only, so the host need not clock the link.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_r <= S_IDLE;
      cnt_r   <= '0;
      op_r    <= OP_NONE;
      addr_r  <= '0;
      data_r  <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= (state_r == S_IDLE || phase_done) ? '0 : cnt_r + 1'b1;
      if (start) begin
        op_r   <= cmd_bus.cmd_op;
        addr_r <= cmd_bus.cmd_addr;
        data_r <= cmd_bus.cmd_data;
      end
    end
  end

  // Array update at the end of each phase; whole-array operations touch every word.
  always_ff @(posedge clock) begin
    for (int i = 0; i < WORDS; i++) begin
      if (phase_done && (whole || addr_r == ADDR_W'(i))) begin
        if (state_r == S_CLEAR) mem_r[i] <= '1;
        else if (state_r == S_STORE) mem_r[i] <= data_r;
      end
    end
  end

  // Status output: armed when a cycle starts, released by a dummy one once ready.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      poll_r        <= 1'b0;
      serial_out    <= 1'b1;
      serial_out_en <= 1'b0;
      busy          <= 1'b0;
      write_enabled <= 1'b0;
      peek_data     <= '0;
    end else begin
      if (start) poll_r <= 1'b1;
      else if (state_r == S_IDLE && cs_now && dum_sync_r[1]) poll_r <= 1'b0; // Busy cannot be released.
      serial_out    <= state_r == S_IDLE && !start;
      serial_out_en <= cs_now && (poll_r || start);
      busy          <= state_r != S_IDLE || start;
      write_enabled <= wen_r;
      peek_data     <= mem_r[peek_addr];
    end
  end
endmodule : eeprom_prog_ctrl

// ==== testbench/prog_ctrl_sva.sv ====
// Port checker for the program control block.
module prog_ctrl_checker #(
  parameter int PROG_COUNT = 8
)(
  // Core clock and reset.
  input wire logic                                clock,
  input wire logic                                rst_b,
  // Link pins, status and word view.
  input wire logic                                serial_clock_in,
  input wire logic                                chip_select,
  input wire logic                                serial_in,
  input wire logic                                serial_out,
  input wire logic                                serial_out_en,
  input wire logic                                busy,
  input wire logic                                write_enabled,
  input wire logic [eeprom_prog_pkg::ADDR_W-1:0] peek_addr,
  input wire logic [eeprom_prog_pkg::DATA_W-1:0] peek_data
);
  import eeprom_prog_pkg::*;
  logic [15:0] busy_cnt_r;
  // Length of the running cycle in core clocks.
  always_ff @(posedge clock) busy_cnt_r <= (!rst_b || !busy) ? 16'h0000 : busy_cnt_r + 16'h0001;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // Select held long enough that no earlier fall can still be in the synchroniser.
  sequence sel_held_s;
    chip_select [*6];
  endsequence
  launch_delay_a: assert property ($rose(busy) |-> !$past(chip_select) && !$past(chip_select, 2) &&
    ($past(chip_select, 3) || $past(chip_select, 4) || $past(chip_select, 5) || $past(chip_select, 6)))
    else $error("busy not tied to select fall");
  launch_wen_a: assert property ($rose(busy) |-> write_enabled)
    else $error("cycle while disabled");
  busy_length_a: assert property ($fell(busy) |-> busy_cnt_r == PROG_COUNT + 1 || busy_cnt_r == 2 * PROG_COUNT + 1)
    else $error("cycle length wrong");
  poll_busy_a: assert property (busy && $past(busy) && $past(busy, 2) && serial_out_en |-> !serial_out)
    else $error("ready shown while busy");
  poll_ready_a: assert property (!busy && !$past(busy) && serial_out_en |-> serial_out)
    else $error("busy shown while idle");
  wen_quiet_a: assert property ($changed(write_enabled) |-> !chip_select && !busy)
    else $error("enable changed out of turn");
  sel_no_launch_a: assert property (sel_held_s |-> !$rose(busy))
    else $error("cycle while selected");
  desel_quiet_a: assert property (!chip_select [*6] |-> !serial_out_en)
    else $error("output driven unselected");
endmodule // prog_ctrl_checker

// ==== testbench/host_link_model.sv ====
// Host model driving the three-wire instruction link.
module host_link_model (
  // Link pins toward the device.
  output logic serial_clock_in,
  output logic chip_select,
  output logic serial_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Between frames the link clock stands still and idle data shows the inverse of its last bit.
  initial begin
    serial_clock_in = 1'b0;
    chip_select     = 1'b0;
    serial_in       = 1'b1;
  end
  // One 64 ns link period; data moves on the low half so it is settled at the rising edge.
  task automatic pulse(input logic b);
    serial_in = b;
    #32 serial_clock_in = 1'b1;
    #32 serial_clock_in = 1'b0;
  endtask
  // Shifts n bits MSB first, then stays deselected past the minimum deselect time.
  task automatic send(input logic [24:0] bits, input int n);
    chip_select = 1'b1;
    #13;
    for (int i = n - 1; i >= 0; i--) pulse(bits[i]);
    chip_select = 1'b0;
    serial_in = ~serial_in;
    #200;
  endtask
endmodule // host_link_model

// ==== testbench/test_serial_eeprom_program_control.sv ====
// Self-checking bench for the program control block.
module test_serial_eeprom_program_control
  import eeprom_prog_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PC = 12;
  logic              clock = 1'b0;
  logic              rst_b = 1'b0;
  logic              serial_clock_in, chip_select, serial_in, serial_out, serial_out_en, busy, write_enabled;
  logic [ADDR_W-1:0] peek_addr = '0;
  logic [ADDR_W-1:0] a;
  logic [DATA_W-1:0] peek_data, d;
  logic [DATA_W-1:0] exp_mem [64];
  int                n_errors = 0;
  int                num_checks = 0;
  int                seed = 32'he905_f293;
  // Core clock of 40 ns.
  always #20 clock = ~clock;
  host_link_model host (.serial_clock_in(serial_clock_in), .chip_select(chip_select), .serial_in(serial_in));
  eeprom_prog_ctrl #(.PROG_COUNT(PC)) dut (.clock(clock), .rst_b(rst_b), .serial_clock_in(serial_clock_in),
    .chip_select(chip_select), .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en),
    .busy(busy), .write_enabled(write_enabled), .peek_addr(peek_addr), .peek_data(peek_data));
  // Compares one value and counts it.
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Expected array after an operation; erased words read as all ones.
  function automatic void model(prog_op_t k, logic [ADDR_W-1:0] ka, logic [DATA_W-1:0] kd);
    for (int i = 0; i < 64; i++) exp_mem[i] = (k == OP_FILL_ALL || (k == OP_WRITE && i == ka)) ? kd :
      (k == OP_CLEAR_ALL || (k == OP_ERASE && i == ka)) ? 16'hffff : exp_mem[i];
  endfunction
  // Special-group instruction of nine bits.
  function automatic logic [24:0] spec(logic [1:0] s);
    return 25'({1'b1, OPC_SPECIAL, s, 4'h0});
  endfunction
  // Bounded wait; running out counts a mismatch and ends the run.
  task automatic wait_busy(input logic lvl);
    for (int c = 0; c < 400 && busy !== lvl; c++) begin
      @(posedge clock);
      #1;
    end
    if (busy !== lvl) begin
      check(busy, lvl);
      wrap_up();
    end
  endtask
  // Sends one instruction; a program cycle is polled busy, then ready, then released by a dummy one.
  task automatic op(input logic [24:0] bits, input int n, input logic prog);
    host.send(bits, n);
    if (!prog) begin
      repeat (4) @(posedge clock);
      #1;
      check(busy, 1'b0);
    end else begin
      wait_busy(1'b1);
      host.chip_select = 1'b1;
      repeat (4) @(posedge clock);
      #1;
      check({serial_out_en, serial_out}, 2'b10);
      wait_busy(1'b0);
      repeat (3) @(posedge clock);
      #1;
      check({serial_out_en, serial_out}, 2'b11);
      host.pulse(1'b1);
      repeat (4) @(posedge clock);
      #1;
      check(serial_out_en, 1'b0);
      host.chip_select = 1'b0;
      #200;
    end
  endtask
  // Reads every word through the view port.
  task automatic check_mem();
    for (int i = 0; i < 64; i++) begin
      @(posedge clock);
      peek_addr <= i[ADDR_W-1:0];
      repeat (2) @(posedge clock);
      #1;
      check(peek_data, exp_mem[i]);
    end
  endtask
  // Main sequence; the second write overwrites zeros with ones to expose a missing pre-clear.
  initial begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    repeat (5) @(posedge clock);
    #1;
    check({busy, write_enabled, serial_out_en}, 3'b000);
    op(25'({1'b1, OPC_ERASE, 6'h2a}), 9, 1'b0);
    op(spec(SUB_ENABLE), 9, 1'b0);
    check(write_enabled, 1'b1);
    op(spec(SUB_CLEAR), 9, 1'b1);
    model(OP_CLEAR_ALL, '0, '0);
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($random(seed));
      a = (i == 1) ? a : 6'($random(seed));
      op({1'b1, OPC_WRITE, a, d}, 25, 1'b1);
      model(OP_WRITE, a, d);
    end
    op(25'({1'b1, OPC_ERASE, a}), 9, 1'b1);
    model(OP_ERASE, a, '0);
    check_mem();
    op(spec(SUB_DISABLE), 9, 1'b0);
    check(write_enabled, 1'b0);
    op({1'b1, OPC_WRITE, 6'h15, 16'h0000}, 25, 1'b0);
    op({1'b1, OPC_SPECIAL, SUB_FILL, 4'h0, 16'h0000}, 25, 1'b0);
    op(25'({1'b1, OPC_ERASE, a}), 9, 1'b0);
    op(spec(SUB_CLEAR), 9, 1'b0);
    check_mem();
    op(spec(SUB_ENABLE), 9, 1'b0);
    d = 16'($random(seed));
    op({1'b1, OPC_SPECIAL, SUB_FILL, 4'h0, d}, 25, 1'b1);
    model(OP_FILL_ALL, '0, d);
    check_mem();
    wrap_up();
  end
endmodule // test_serial_eeprom_program_control
// Attaches the port checker to the control block.
bind eeprom_prog_ctrl prog_ctrl_checker #(.PROG_COUNT(PROG_COUNT)) chk (.clock(clock), .rst_b(rst_b),
  .serial_clock_in(serial_clock_in), .chip_select(chip_select), .serial_in(serial_in), .serial_out(serial_out),
  .serial_out_en(serial_out_en), .busy(busy), .write_enabled(write_enabled), .peek_addr(peek_addr),
  .peek_data(peek_data));
